// ===== glc_amp_avg.v
// amplitude averager over 8, 16, 32 or 64 channel filter samples
`timescale 1ns/1ps
module glc_amp_avg #(
	parameter MAG_W = 8
) (
	// clock and reset
	input  wire             clock_in,
	input  wire             rst_n_in,
	// control
	input  wire             enable_in,
	input  wire [1:0]       len_sel_in,
	// samples
	input  wire             sample_valid_in,
	input  wire [MAG_W-1:0] sample_mag_in,
	// result
	output reg              done_out,
	output reg  [MAG_W-1:0] avg_out
);
	reg  [MAG_W+5:0] acc;
	reg  [5:0]       count;
	wire [5:0]       last_idx;
	wire [MAG_W+5:0] sum;
	wire [MAG_W+5:0] scaled;

	assign last_idx = (6'h08 << len_sel_in) - 6'h01;
	assign sum      = acc + {6'h00, sample_mag_in};
	// divide by the full window so long windows keep their top bits
	assign scaled   = sum >> ({1'b0, len_sel_in} + 3'h3);

	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			acc      <= {(MAG_W+6){1'b0}};
			count    <= 6'h00;
			done_out <= 1'b0;
			avg_out  <= {MAG_W{1'b0}};
		end else begin
			done_out <= 1'b0;
			// disabled means settling: drop partial sums so stale data never mixes in
			if (!enable_in) begin
				acc   <= {(MAG_W+6){1'b0}};
				count <= 6'h00;
			end else if (sample_valid_in) begin
				if (count == last_idx) begin
					avg_out  <= scaled[MAG_W-1:0];
					done_out <= 1'b1;
					acc      <= {(MAG_W+6){1'b0}};
					count    <= 6'h00;
				end else begin
					acc   <= sum;
					count <= count + 6'h01;
				end
			end
		end
	end
endmodule // glc_amp_avg

// ===== glc_consts.vh
// constants for the gain loop control block
`ifndef GLC_CONSTS_VH
`define GLC_CONSTS_VH

// register map
`define GLC_CONFIG_ADDR      8'h1c
`define GLC_CONFIG_RESET     8'h91

// field positions in gain_loop_config
`define GLC_HYST_MSB         7
`define GLC_HYST_LSB         6
`define GLC_WAIT_MSB         5
`define GLC_WAIT_LSB         4
`define GLC_HOLD_MSB         3
`define GLC_HOLD_LSB         2
`define GLC_AVG_MSB          1
`define GLC_AVG_LSB          0

// gain hold policies
`define GLC_HOLD_NORMAL      2'h0
`define GLC_HOLD_ON_SYNC     2'h1
`define GLC_HOLD_ANALOG      2'h2
`define GLC_HOLD_ALL         2'h3

// settle wait: samples per wait step, and ook boundary dB per step
`define GLC_WAIT_STEP        6'h08
`define GLC_OOK_STEP_DB      5'h04

// dead zone edges (above target, below target) per hysteresis setting
`define GLC_UP_THR_0         10'h002
`define GLC_DN_THR_0         10'h002
`define GLC_UP_THR_1         10'h002
`define GLC_DN_THR_1         10'h004
`define GLC_UP_THR_2         10'h003
`define GLC_DN_THR_2         10'h006
`define GLC_UP_THR_3         10'h004
`define GLC_DN_THR_3         10'h008

`endif

// ===== glc_loop_ctrl.v
// gain loop control: config register, settle wait, averaging, gain decisions
// Contract
// - two-bit hysteresis select, reset 2; sets dead zone and gain bias
// - after gain change wait 8, 16, 24 or 32 samples; reset 1
// - hold policy 0, the reset value: adjust gain whenever needed
// - hold policy 1: stop changing gain once sync word found
// - hold policy 2: hold analogue gain, keep adjusting digital gain
// - hold policy 3: freeze both gains, allow manual override
// - averaging select, reset 1, averages 8, 16, 32 or 64 samples
// - averaging select also sets OOK boundary 4, 8, 12, 16 dB
`timescale 1ns/1ps
`include "glc_consts.vh"
module glc_loop_ctrl #(
	parameter       MAG_W       = 8,
	parameter       GAIN_W      = 3,
	parameter [7:0] MAG_TARGET  = 8'h40
) (
	// clock and reset
	input  wire              clock_in,
	input  wire              rst_n_in,
	// register port
	input  wire [7:0]        reg_addr_in,
	input  wire              reg_wr_in,
	input  wire [7:0]        reg_wdata_in,
	input  wire              reg_rd_in,
	output reg  [7:0]        reg_rdata_out,
	// channel filter samples and receiver events
	input  wire              sample_valid_in,
	input  wire [MAG_W-1:0]  sample_mag_in,
	input  wire              sync_found_in,
	input  wire              rx_restart_in,
	// manual gain override
	input  wire              manual_load_in,
	input  wire [GAIN_W-1:0] manual_analog_in,
	input  wire [GAIN_W-1:0] manual_digital_in,
	// gain outputs and status
	output reg  [GAIN_W-1:0] analog_gain_out,
	output reg  [GAIN_W-1:0] digital_gain_out,
	output reg               gain_frozen_out,
	output reg               settling_out,
	output reg  [4:0]        ook_boundary_db_out
);
	localparam ST_SETTLE = 1'b0;
	localparam ST_ACCUM  = 1'b1;
	localparam [GAIN_W-1:0] GAIN_MAX = {GAIN_W{1'b1}};

	reg  [7:0]        config_reg;
	reg               state;
	reg  [5:0]        settle_cnt;
	reg               sync_latched;
	wire [1:0]        hyst_sel;
	wire [1:0]        wait_sel;
	wire [1:0]        hold_sel;
	wire [1:0]        avg_sel;
	wire              avg_done;
	wire [MAG_W-1:0]  avg_mag;
	wire [5:0]        settle_last;
	reg  [9:0]        up_thr;
	reg  [9:0]        dn_thr;
	wire signed [9:0] deviation;
	reg               want_down;
	reg               want_up;
	reg               analog_held;
	reg               all_held;
	wire              sync_hold;

	assign hyst_sel    = config_reg[`GLC_HYST_MSB:`GLC_HYST_LSB];
	assign wait_sel    = config_reg[`GLC_WAIT_MSB:`GLC_WAIT_LSB];
	assign hold_sel    = config_reg[`GLC_HOLD_MSB:`GLC_HOLD_LSB];
	assign avg_sel     = config_reg[`GLC_AVG_MSB:`GLC_AVG_LSB];
	assign settle_last = `GLC_WAIT_STEP * ({4'h0, wait_sel} + 6'h01) - 6'h01;
	assign deviation   = $signed({2'b00, avg_mag}) - $signed({2'b00, MAG_TARGET});
	// a sync seen in the deciding cycle already blocks that decision
	assign sync_hold   = sync_latched | sync_found_in;

	//////////////////////////////////////////////////////////////////////////////
	// register port
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			config_reg    <= `GLC_CONFIG_RESET;
			reg_rdata_out <= 8'h00;
		end else begin
			if (reg_wr_in && reg_addr_in == `GLC_CONFIG_ADDR)
				config_reg <= reg_wdata_in;
			// unmapped reads return zero
			if (reg_rd_in)
				reg_rdata_out <= (reg_addr_in == `GLC_CONFIG_ADDR) ? config_reg : 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// dead zone and hold decisions
	always @* begin
		// larger hysteresis widens the lower edge at every step, the upper edge only from setting 2 on
		case (hyst_sel)
			2'h0: begin
				up_thr = `GLC_UP_THR_0;
				dn_thr = `GLC_DN_THR_0;
			end
			2'h1: begin
				up_thr = `GLC_UP_THR_1;
				dn_thr = `GLC_DN_THR_1;
			end
			2'h2: begin
				up_thr = `GLC_UP_THR_2;
				dn_thr = `GLC_DN_THR_2;
			end
			default: begin
				up_thr = `GLC_UP_THR_3;
				dn_thr = `GLC_DN_THR_3;
			end
		endcase
		// wider lower edge raises gain less eagerly, so the loop leans to low gain
		want_down = deviation > $signed(up_thr);
		want_up   = deviation < -$signed(dn_thr);
		// held gains are masked here; the state machine reads hold_sel only for the manual load
		case (hold_sel)
			`GLC_HOLD_NORMAL: begin
				analog_held = 1'b0;
				all_held    = 1'b0;
			end
			`GLC_HOLD_ON_SYNC: begin
				analog_held = sync_hold;
				all_held    = sync_hold;
			end
			`GLC_HOLD_ANALOG: begin
				analog_held = 1'b1;
				all_held    = 1'b0;
			end
			default: begin
				analog_held = 1'b1;
				all_held    = 1'b1;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	// averager
	// runs only while accumulating, so leaving that state drops the partial window
	glc_amp_avg #(
		.MAG_W           (MAG_W)
	) u_avg (
		.clock_in        (clock_in),
		.rst_n_in        (rst_n_in),
		.enable_in       (state == ST_ACCUM),
		.len_sel_in      (avg_sel),
		.sample_valid_in (sample_valid_in),
		.sample_mag_in   (sample_mag_in),
		.done_out        (avg_done),
		.avg_out         (avg_mag)
	);

	//////////////////////////////////////////////////////////////////////////////
	// gain loop
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			state               <= ST_SETTLE;
			settle_cnt          <= 6'h00;
			sync_latched        <= 1'b0;
			// start at the top so weak signals are not lost while converging
			analog_gain_out     <= GAIN_MAX;
			digital_gain_out    <= GAIN_MAX;
			gain_frozen_out     <= 1'b0;
			settling_out        <= 1'b1;
			ook_boundary_db_out <= 5'h00;
		end else begin
			ook_boundary_db_out <= `GLC_OOK_STEP_DB * ({3'h0, avg_sel} + 5'h01);
			gain_frozen_out     <= all_held;
			settling_out        <= (state == ST_SETTLE);
			// sync flag lives until the receiver restarts; a sync in that cycle wins
			if (sync_found_in)
				sync_latched <= 1'b1;
			else if (rx_restart_in)
				sync_latched <= 1'b0;
			if (hold_sel == `GLC_HOLD_ALL && manual_load_in) begin
				analog_gain_out  <= manual_analog_in;
				digital_gain_out <= manual_digital_in;
			end
			// settle, then accumulate; every gain step goes back to settle
			case (state)
				ST_SETTLE: begin
					if (sample_valid_in) begin
						if (settle_cnt >= settle_last) begin
							state      <= ST_ACCUM;
							settle_cnt <= 6'h00;
						end else begin
							settle_cnt <= settle_cnt + 6'h01;
						end
					end
				end
				ST_ACCUM: begin
					if (avg_done && !all_held) begin
						// analogue stage moves first when allowed, digital takes the rest
						if (want_down) begin
							state <= ST_SETTLE;
							if (!analog_held && analog_gain_out != {GAIN_W{1'b0}})
								analog_gain_out <= analog_gain_out - 1'b1;
							else if (digital_gain_out != {GAIN_W{1'b0}})
								digital_gain_out <= digital_gain_out - 1'b1;
							else
								state <= ST_ACCUM;
						end else if (want_up) begin
							state <= ST_SETTLE;
							if (!analog_held && analog_gain_out != GAIN_MAX)
								analog_gain_out <= analog_gain_out + 1'b1;
							else if (digital_gain_out != GAIN_MAX)
								digital_gain_out <= digital_gain_out + 1'b1;
							else
								state <= ST_ACCUM;
						end
					end
				end
				default: state <= ST_SETTLE;
			endcase

			// a manual load is a gain change too, so amplitudes must settle again
			if (hold_sel == `GLC_HOLD_ALL && manual_load_in) begin
				state      <= ST_SETTLE;
				settle_cnt <= 6'h00;
			end
		end
	end
endmodule // glc_loop_ctrl

// ===== glc_loop_ctrl_chk.sv
// checker for the gain loop control block
`timescale 1ns/1ps
module glc_loop_ctrl_chk #(parameter GAIN_W = 3) (
	// clock, reset, register port
	input wire              clock_in,
	input wire              rst_n_in,
	input wire [7:0]        reg_addr_in,
	input wire              reg_wr_in,
	input wire [7:0]        reg_wdata_in,
	input wire              reg_rd_in,
	input wire [7:0]        reg_rdata_out,
	// gains and status
	input wire              manual_load_in,
	input wire [GAIN_W-1:0] analog_gain_out,
	input wire [GAIN_W-1:0] digital_gain_out,
	input wire              gain_frozen_out,
	input wire              settling_out,
	input wire [4:0]        ook_boundary_db_out
);
	reg [7:0] cfg;
	// mirror of the config register at its field defaults
	always @(posedge clock_in)
		if (!rst_n_in)
			cfg <= 8'h91;
		else if (reg_wr_in && reg_addr_in == 8'h1c)
			cfg <= reg_wdata_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	sequence gain_move;
		($changed(analog_gain_out) || $changed(digital_gain_out)) && !$past(manual_load_in);
	endsequence
	ook_bound_a: assert property ($past(rst_n_in) |->
		ook_boundary_db_out == {$past(cfg[1:0]) + 3'h1, 2'h0}) else $error("ook boundary wrong");
	cfg_read_a: assert property (reg_rd_in |=> reg_rdata_out ==
		($past(reg_addr_in) == 8'h1c ? $past(cfg) : 8'h00)) else $error("read data wrong");
	rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved");
	analog_hold_a: assert property (cfg[3:2] == 2'h2 && $past(cfg[3:2]) == 2'h2
		|=> $stable(analog_gain_out)) else $error("analog gain moved");
	all_hold_a: assert property (cfg[3:2] == 2'h3 && $past(cfg[3:2]) == 2'h3 && !manual_load_in
		|=> $stable(analog_gain_out) && $stable(digital_gain_out)) else $error("gain moved");
	frozen_flag_a: assert property ($past(cfg[3:2]) == 2'h3 |-> gain_frozen_out)
		else $error("frozen flag low");
	gain_step_a: assert property (gain_move |-> analog_gain_out - $past(analog_gain_out)
		+ digital_gain_out - $past(digital_gain_out) inside {1, -1}) else $error("gain jump");
	settle_start_a: assert property (gain_move |=> settling_out)
		else $error("no settle after gain change");
endmodule // glc_loop_ctrl_chk
bind glc_loop_ctrl glc_loop_ctrl_chk #(.GAIN_W(GAIN_W)) u_chk (
	.clock_in            (clock_in),
	.rst_n_in            (rst_n_in),
	.reg_addr_in         (reg_addr_in),
	.reg_wr_in           (reg_wr_in),
	.reg_wdata_in        (reg_wdata_in),
	.reg_rd_in           (reg_rd_in),
	.reg_rdata_out       (reg_rdata_out),
	.manual_load_in      (manual_load_in),
	.analog_gain_out     (analog_gain_out),
	.digital_gain_out    (digital_gain_out),
	.gain_frozen_out     (gain_frozen_out),
	.settling_out        (settling_out),
	.ook_boundary_db_out (ook_boundary_db_out)
);

// ===== glc_loop_ctrl_tb.sv
// self-checking bench for the gain loop control block
`timescale 1ns/1ps
module glc_loop_ctrl_tb;
	reg        clock_in = 1'b0;
	reg        rst_n_in = 1'b0;
	reg        wr = 1'b0, rd = 1'b0, sync = 1'b0, ld = 1'b0, en = 1'b0, rx = 1'b0;
	reg  [7:0] addr = 8'h00, wdata = 8'h00, mag = 8'h00;
	reg  [2:0] k;
	wire [7:0] rdata, cnt, smag;
	wire [2:0] ana, dig;
	wire [4:0] ook;
	wire       sval, frz;
	integer    n_fail = 0, checked = 0, i;
	always #2.5 clock_in = ~clock_in;
	glc_loop_ctrl i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.sample_valid_in(sval), .sample_mag_in(smag), .sync_found_in(sync),
		.rx_restart_in(rx), .manual_load_in(ld), .manual_analog_in(3'h3),
		.manual_digital_in(3'h5), .analog_gain_out(ana), .digital_gain_out(dig),
		.gain_frozen_out(frz), .settling_out(), .ook_boundary_db_out(ook));
	glc_sample_src i_src (.clock_in(clock_in), .en_in(en), .mag_in(mag),
		.valid_out(sval), .mag_out(smag), .count_out(cnt));
	////////////////////////////////////////////////////////////////
	task results;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
		checked = checked + 1;
		if (e !== g) begin
			n_fail = n_fail + 1;
			$display("mismatch %0s exp %h got %h", nm, e, g);
		end
	endtask
	task wr_reg(input [7:0] a, input [7:0] d);
		@(negedge clock_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clock_in);
		wr = 1'b0;
	endtask
	task rd_reg(input [7:0] a, input [7:0] e);
		@(negedge clock_in);
		addr = a;
		rd = 1'b1;
		@(negedge clock_in);
		rd = 1'b0;
		chk("rdata", e, rdata);
	endtask
	task reset;
		rst_n_in = 1'b0;
		en = 1'b0;
		sync = 1'b0;
		repeat (2) @(negedge clock_in);
		rst_n_in = 1'b1;
	endtask
	// samples counted up to the first gain move; n of zero means none may move
	task run(input [7:0] c, input [7:0] m, input s, input [7:0] n, input [2:0] ea, ed);
		reset;
		wr_reg(8'h1c, c);
		sync = s;
		mag = m;
		en = 1'b1;
		for (i = 0; i < 600 && ana === 3'h7 && dig === 3'h7; i = i + 1)
			@(negedge clock_in);
		if (n != 8'h00)
			chk("samples", n, cnt);
		chk("analog", {5'h00, ea}, {5'h00, ana});
		chk("digital", {5'h00, ed}, {5'h00, dig});
		chk("frozen", {7'h00, c[3:2] == 2'h3 || (s && c[3:2] == 2'h1)}, {7'h00, frz});
		if (n != 8'h00 && i == 600) begin
			n_fail = n_fail + 1;
			$display("mismatch gain_move exp 1 got 0");
			results;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		reset;
		rd_reg(8'h1c, 8'h91);
		chk("ook", 8'h08, {3'h0, ook});
		for (k = 3'h0; k < 3'h4; k = k + 3'h1) begin
			wr_reg(8'h1c, {6'h24, k[1:0]});
			@(negedge clock_in);
			chk("ook", {1'b0, k + 3'h1, 2'h0}, {3'h0, ook});
		end
		wr_reg(8'h1d, 8'h00);
		rd_reg(8'h1c, 8'h93);
		rd_reg(8'h1d, 8'h00);
		run(8'h91, 8'h60, 1'b0, 8'd32, 3'h6, 3'h7);
		run(8'h00, 8'h43, 1'b0, 8'd16, 3'h6, 3'h7);
		run(8'hf0, 8'h43, 1'b0, 8'd0, 3'h7, 3'h7);
		run(8'h33, 8'h60, 1'b0, 8'd96, 3'h6, 3'h7);
		run(8'h22, 8'h60, 1'b0, 8'd56, 3'h6, 3'h7);
		run(8'h99, 8'h60, 1'b0, 8'd32, 3'h7, 3'h6);
		run(8'h95, 8'h60, 1'b1, 8'd0, 3'h7, 3'h7);
		sync = 1'b0;
		rx = 1'b1;
		@(negedge clock_in);
		rx = 1'b0;
		for (i = 0; i < 600 && ana === 3'h7; i = i + 1)
			@(negedge clock_in);
		chk("analog", 8'h06, {5'h00, ana});
		if (i == 600)
			results;
		run(8'h95, 8'h60, 1'b0, 8'd32, 3'h6, 3'h7);
		run(8'h9d, 8'h60, 1'b0, 8'd0, 3'h7, 3'h7);
		@(negedge clock_in);
		ld = 1'b1;
		@(negedge clock_in);
		ld = 1'b0;
		chk("analog", 8'h03, {5'h00, ana});
		chk("digital", 8'h05, {5'h00, dig});
		results;
	end
endmodule // glc_loop_ctrl_tb

// ===== glc_sample_src.sv
// channel filter sample source for the gain loop bench
`timescale 1ns/1ps
module glc_sample_src (
	// clock and control
	input  wire       clock_in,
	input  wire       en_in,
	input  wire [7:0] mag_in,
	// sample stream
	output reg        valid_out,
	output reg  [7:0] mag_out,
	output reg  [7:0] count_out
);
	reg [1:0] phase;
	initial begin
		phase = 2'h0;
		valid_out = 1'b0;
		mag_out = 8'h00;
		count_out = 8'h00;
	end
	// one sample every fourth cycle; magnitude is scrambled between samples
	// launched on the rising edge so the bench's falling-edge enable never races it
	always @(posedge clock_in) begin
		phase <= phase + 2'h1;
		valid_out <= en_in && phase == 2'h3;
		mag_out <= (en_in && phase == 2'h3) ? mag_in : ~mag_out;
		count_out <= en_in ? count_out + {7'h00, valid_out} : 8'h00;
	end
endmodule // glc_sample_src
